// file: design/lulc_defines.svh
// Constants for the line unit loss, loopback and jitter control block.
`ifndef LULC_DEFINES_SVH
`define LULC_DEFINES_SVH

// ****************************************************************
// Loss of signal
// ****************************************************************
`define LULC_LOS_STD_BITS 12'h0c0
`define LULC_LOS_ETS_BITS 12'h800
`define LULC_WIN_BITS 8'hc0
`define LULC_ONES_MIN 8'h18
`define LULC_ZRUN_PLAIN 8'h64
`define LULC_ZRUN_ZSUB 8'h08

// ****************************************************************
// Jitter attenuator
// ****************************************************************
`define LULC_JA_DEEP 8'h80
`define LULC_JA_SHALLOW 8'h20
`define LULC_JA_LIM_DEEP 8'h78
`define LULC_JA_LIM_SHALLOW 8'h1c
`define LULC_JA_RX 2'h1
`define LULC_JA_TX 2'h2
`define LULC_CORNER_T1_MHZ 12'hea6
`define LULC_CORNER_E1_MHZ 12'h258

// ****************************************************************
// Timing
// ****************************************************************
`define LULC_BIT_NS 488
`define LULC_CLK_MHZ 125
`define LULC_BIT_CYC ((`LULC_BIT_NS * `LULC_CLK_MHZ) / 1000)

`endif

// file: design/lulc_pkg.sv
// Types for the line unit loss, loopback and jitter control block.
package lulc_pkg;
    typedef enum logic {LULC_ST_CLEAR, LULC_ST_LOST} lulc_los_state_e;
endpackage : lulc_pkg

// file: design/lulc_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ns
module lulc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o,
    output logic [$clog2(DEPTH):0] level_o
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("lulc_fifo: DEPTH must be a power of two, at least 2.");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wr_q;
    logic [AW:0] rd_q;
    wire do_wr = in_valid_i && in_ready_o;
    wire do_rd = out_valid_o && out_ready_i;

    assign level_o = wr_q - rd_q;
    assign in_ready_o = level_o != (AW+1)'(DEPTH);
    assign out_valid_o = wr_q != rd_q;
    assign out_data_o = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge sys_clk_i) begin
        if (do_wr) begin
            mem_q[wr_q[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(do_wr);
            rd_q <= rd_q + (AW+1)'(do_rd);
        end
    end
endmodule : lulc_fifo

// file: design/lulc_los_detect.sv
// Loss of signal declaration and reset counting for one port.
`timescale 1ns/1ns
`include "lulc_defines.svh"
module lulc_los_detect (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic bit_stb_i,
    input wire logic pulse_i,
    input wire logic level_ok_i,
    input wire logic level_low_i,
    input wire logic t1_mode_i,
    input wire logic ets_mode_i,
    input wire logic zero_sub_i,
    output logic los_o
);
    lulc_pkg::lulc_los_state_e state_q;
    logic [11:0] low_cnt_q;
    logic [7:0] ok_cnt_q;
    logic [7:0] win_cnt_q;
    logic [7:0] ones_q;
    logic [7:0] zrun_q;
    logic zbad_q;

    // The long standard only exists in E1; T1 ignores the selector.
    wire [11:0] decl_bits = (!t1_mode_i && ets_mode_i) ? `LULC_LOS_ETS_BITS
                                                      : `LULC_LOS_STD_BITS;
    wire [7:0] zrun_lim = zero_sub_i ? `LULC_ZRUN_ZSUB : `LULC_ZRUN_PLAIN;
    wire is_one = pulse_i && level_ok_i;
    wire [11:0] low_inc = (&low_cnt_q) ? low_cnt_q : low_cnt_q + 12'h001;
    wire [7:0] ok_inc = (&ok_cnt_q) ? ok_cnt_q : ok_cnt_q + 8'h01;
    wire [7:0] zr_inc = (&zrun_q) ? zrun_q : zrun_q + 8'h01;
    wire [7:0] ones_d = ones_q + {7'h00, is_one};
    wire zbad_d = zbad_q || (!is_one && zr_inc >= zrun_lim);
    wire win_end = win_cnt_q == `LULC_WIN_BITS - 8'h01;
    wire declare = level_low_i && low_inc >= decl_bits;
    wire t1_clear = win_end && ones_d >= `LULC_ONES_MIN && !zbad_d;
    wire e1_clear = level_ok_i && ok_inc >= `LULC_WIN_BITS;

    assign los_o = state_q == lulc_pkg::LULC_ST_LOST;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            low_cnt_q <= 12'h000;
            ok_cnt_q <= 8'h00;
        end else if (bit_stb_i) begin
            low_cnt_q <= level_low_i ? low_inc : 12'h000;
            ok_cnt_q <= level_ok_i ? ok_inc : 8'h00;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state_q <= lulc_pkg::LULC_ST_LOST;
        end else if (bit_stb_i) begin
            case (state_q)
                lulc_pkg::LULC_ST_CLEAR: begin
                    if (declare) begin
                        state_q <= lulc_pkg::LULC_ST_LOST;
                    end
                end
                lulc_pkg::LULC_ST_LOST: begin
                    if (t1_mode_i ? t1_clear : e1_clear) begin
                        state_q <= lulc_pkg::LULC_ST_CLEAR;
                    end
                end
                default: state_q <= lulc_pkg::LULC_ST_LOST;
            endcase
        end
    end

    // The window restarts at every loss entry so clearing needs a full window.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !los_o) begin
            win_cnt_q <= 8'h00;
            ones_q <= 8'h00;
            zrun_q <= 8'h00;
            zbad_q <= 1'b0;
        end else if (bit_stb_i) begin
            win_cnt_q <= win_end ? 8'h00 : win_cnt_q + 8'h01;
            ones_q <= win_end ? 8'h00 : ones_d;
            zrun_q <= is_one ? 8'h00 : zr_inc;
            zbad_q <= win_end ? 1'b0 : zbad_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    property p_ets_hold;
        (!t1_mode_i && ets_mode_i && !los_o && bit_stb_i && level_low_i
         && low_cnt_q < 12'h7fe) |=> !los_o;
    endproperty
    a_ets_hold: assert property (p_ets_hold) else $error("Early loss.");

    property p_t1_ones;
        (t1_mode_i && los_o && bit_stb_i && win_end && ones_q < 8'h17) |=> los_o;
    endproperty
    a_t1_ones: assert property (p_t1_ones) else $error("Loss cleared too soon.");

    property p_std_decl;
        (!(!t1_mode_i && ets_mode_i) && !los_o && bit_stb_i && level_low_i
         && low_cnt_q == 12'h0bf) |=> los_o;
    endproperty
    a_std_decl: assert property (p_std_decl) else $error("Loss missed.");
endmodule : lulc_los_detect

// file: design/lulc_line_unit.sv
// Per-port line unit control: loss, hitless switching, jitter, loopbacks.
`timescale 1ns/1ns
`include "lulc_defines.svh"

// Functional notes
// - Declare loss after 192 low bits.
// - T1 clears on 24 ones per window.
// - T1 clear blocked by 100 zero run.
// - E1 clears after 192 good-level bits.
// - Long E1 standard declares after 2048 bits.
// - T1 zero run limit 8 with substitution.
// - Enable pin low tristates transmit outputs.
// - Hitless bit lets pin drop termination.
// - Pin response within one bit period.
// - Jitter buffer depth 32 or 128.
// - Path select: receive, transmit or off.
// - Latched trip above 120 or 28.
// - Smoothed read clock, bursty source tolerated.
// - Corner 3.75Hz T1, 0.6Hz E1.
// - Analog loop feeds transmit into receiver.
// - Local loop returns transmit data inward.
// - Remote loop one bypasses jitter buffer.
// - Remote loop two goes through buffer.
// - Dual loop is local plus remote one.
// - All ones on loss from master clock.
// - Receive clock from master during loss.
module lulc_line_unit (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic line_output_enable_pin_i,
    input wire logic rx_hitless_protect_bit_i,
    input wire logic jitter_buffer_depth_select_i,
    input wire logic jitter_path_select_hi_i,
    input wire logic jitter_path_select_lo_i,
    input wire logic t1_mode_i,
    input wire logic ets_mode_i,
    input wire logic zero_sub_i,
    input wire logic analog_lb_i,
    input wire logic local_lb_i,
    input wire logic remote_lb1_i,
    input wire logic remote_lb2_i,
    input wire logic dual_lb_i,
    input wire logic auto_all_ones_on_loss_i,
    input wire logic rx_bit_stb_i,
    input wire logic rx_line_data_i,
    input wire logic rx_level_ok_i,
    input wire logic rx_level_low_i,
    input wire logic rx_recovered_clock_i,
    input wire logic master_clock_t1_source_i,
    input wire logic mclk_bit_stb_i,
    input wire logic tx_bit_stb_i,
    input wire logic tx_system_serial_data_i,
    input wire logic ja_smooth_stb_i,
    input wire logic los_change_clear_i,
    input wire logic trip_clear_i,
    output logic tx_line_oe_o,
    output logic tx_line_stb_o,
    output logic tx_line_data_o,
    output logic rx_term_en_o,
    output logic rx_system_stb_o,
    output logic rx_system_serial_data_o,
    output logic rx_recovered_clock_o,
    output logic receive_carrier_loss_o,
    output logic los_change_latched_o,
    output logic jitter_limit_trip_flag_o,
    output logic ja_ref_tx_clock_o,
    output logic [11:0] ja_corner_mhz_o,
    output logic [7:0] ja_level_o
);
    // Three pin samples plus the agree stage must fit in one bit period.
    if (`LULC_BIT_CYC < 6) begin : g_chk
        $error("lulc_line_unit: clock too slow for pin response.");
    end

    // ****************************************************************
    // Enable pin synchroniser
    // ****************************************************************
    logic en_s1_q;
    logic en_s2_q;
    logic en_s3_q;
    logic en_q;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            en_s1_q <= 1'b0;
            en_s2_q <= 1'b0;
            en_s3_q <= 1'b0;
        end else begin
            en_s1_q <= line_output_enable_pin_i;
            en_s2_q <= en_s1_q;
            en_s3_q <= en_s2_q;
        end
    end

    // A level change counts once two samples agree, filtering one-cycle glitches.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            en_q <= 1'b0;
        end else if (en_s2_q == en_s3_q) begin
            en_q <= en_s3_q;
        end
    end

    // ****************************************************************
    // Loopback and path selection
    // ****************************************************************
    logic tx_line_stb_q;
    logic tx_line_data_q;
    logic los_w;

    wire lb_local = local_lb_i || dual_lb_i;
    wire lb_rem1 = remote_lb1_i || dual_lb_i;
    wire lb_rem2 = remote_lb2_i && !lb_rem1;
    wire [1:0] ja_path = {jitter_path_select_hi_i, jitter_path_select_lo_i};
    wire ja_in_tx = lb_rem2 || (ja_path == `LULC_JA_TX && !lb_rem1);
    wire ja_in_rx = !ja_in_tx && ja_path == `LULC_JA_RX;
    wire ja_active = ja_in_tx || ja_in_rx;

    // The analog loop takes the registered line output, so no loop forms.
    wire rx_src_stb = analog_lb_i ? tx_line_stb_q : rx_bit_stb_i;
    wire rx_src_data = analog_lb_i ? tx_line_data_q : rx_line_data_i;
    wire rx_src_ok = analog_lb_i || rx_level_ok_i;
    wire rx_src_low = !analog_lb_i && rx_level_low_i;

    wire lb_remote = lb_rem1 || lb_rem2;
    wire tx_src_stb = lb_remote ? rx_src_stb : tx_bit_stb_i;
    wire tx_src_data = lb_remote ? rx_src_data : tx_system_serial_data_i;

    // ****************************************************************
    // Loss detection
    // ****************************************************************
    lulc_los_detect u_los (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .bit_stb_i(rx_src_stb),
        .pulse_i(rx_src_data),
        .level_ok_i(rx_src_ok),
        .level_low_i(rx_src_low),
        .t1_mode_i(t1_mode_i),
        .ets_mode_i(ets_mode_i),
        .zero_sub_i(zero_sub_i),
        .los_o(los_w)
    );

    // ****************************************************************
    // Jitter attenuator buffer
    // ****************************************************************
    logic ja_in_ready;
    logic ja_out_valid;
    logic ja_out_data;
    logic [7:0] ja_level;
    logic primed_q;

    wire ja_wr_valid = ja_in_tx ? tx_src_stb : (ja_in_rx && rx_src_stb);
    wire ja_wr_data = ja_in_tx ? tx_src_data : rx_src_data;
    wire [7:0] ja_cap = jitter_buffer_depth_select_i ? `LULC_JA_DEEP
                                                     : `LULC_JA_SHALLOW;
    wire [7:0] ja_lim = jitter_buffer_depth_select_i ? `LULC_JA_LIM_DEEP
                                                     : `LULC_JA_LIM_SHALLOW;
    wire ja_room = ja_in_ready && ja_level < ja_cap;
    wire ja_push = ja_wr_valid && ja_room;
    // Reads wait until half full so bursts on either side are absorbed.
    wire ja_pull = ja_active ? (primed_q && ja_smooth_stb_i) : 1'b1;
    wire ja_out_stb = ja_active && ja_out_valid && ja_pull;
    wire ja_over = ja_wr_valid && !ja_room;
    wire ja_under = primed_q && ja_smooth_stb_i && !ja_out_valid;
    wire trip_set = ja_active && (ja_level > ja_lim || ja_over || ja_under);

    lulc_fifo #(
        .WIDTH(1),
        .DEPTH(128)
    ) u_ja (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .in_valid_i(ja_push),
        .in_ready_o(ja_in_ready),
        .in_data_i(ja_wr_data),
        .out_valid_o(ja_out_valid),
        .out_ready_i(ja_pull),
        .out_data_o(ja_out_data),
        .level_o(ja_level)
    );

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || !ja_active || !ja_out_valid) begin
            primed_q <= 1'b0;
        end else if (ja_level >= {1'b0, ja_cap[7:1]}) begin
            primed_q <= 1'b1;
        end
    end

    // ****************************************************************
    // Output selection
    // ****************************************************************
    wire tx_ones = auto_all_ones_on_loss_i && los_w;
    wire tx_stb_w = tx_ones ? mclk_bit_stb_i
                  : ja_in_tx ? ja_out_stb : tx_src_stb;
    wire tx_data_w = tx_ones || (ja_in_tx ? ja_out_data : tx_src_data);
    wire rx_stb_w = lb_local ? tx_bit_stb_i
                  : ja_in_rx ? ja_out_stb : rx_src_stb;
    wire rx_data_w = lb_local ? tx_system_serial_data_i
                   : ja_in_rx ? ja_out_data : rx_src_data;
    wire rx_clk_w = los_w ? master_clock_t1_source_i : rx_recovered_clock_i;
    wire [11:0] corner_w = t1_mode_i ? `LULC_CORNER_T1_MHZ : `LULC_CORNER_E1_MHZ;
    wire chg_set = los_w != receive_carrier_loss_o;

    logic tx_line_oe_q;
    logic rx_term_en_q;
    logic rx_sys_stb_q;
    logic rx_sys_data_q;
    logic rx_clk_q;
    logic los_q;
    logic los_chg_q;
    logic trip_q;
    logic ja_ref_q;
    logic [11:0] corner_q;
    logic [7:0] level_q;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_line_oe_q <= 1'b0;
            rx_term_en_q <= 1'b1;
        end else begin
            tx_line_oe_q <= en_q;
            rx_term_en_q <= !(rx_hitless_protect_bit_i && !en_q);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_line_stb_q <= 1'b0;
            tx_line_data_q <= 1'b0;
            rx_sys_stb_q <= 1'b0;
            rx_sys_data_q <= 1'b0;
            rx_clk_q <= 1'b0;
        end else begin
            tx_line_stb_q <= tx_stb_w;
            tx_line_data_q <= tx_data_w;
            rx_sys_stb_q <= rx_stb_w;
            rx_sys_data_q <= rx_data_w;
            rx_clk_q <= rx_clk_w;
        end
    end

    // A new event beats a clear arriving in the same cycle.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            los_q <= 1'b1;
            los_chg_q <= 1'b0;
            trip_q <= 1'b0;
        end else begin
            los_q <= los_w;
            los_chg_q <= chg_set || (los_chg_q && !los_change_clear_i);
            trip_q <= trip_set || (trip_q && !trip_clear_i);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ja_ref_q <= 1'b0;
            corner_q <= `LULC_CORNER_T1_MHZ;
            level_q <= 8'h00;
        end else begin
            ja_ref_q <= ja_in_tx;
            corner_q <= corner_w;
            level_q <= ja_level;
        end
    end

    assign tx_line_oe_o = tx_line_oe_q;
    assign tx_line_stb_o = tx_line_stb_q;
    assign tx_line_data_o = tx_line_data_q;
    assign rx_term_en_o = rx_term_en_q;
    assign rx_system_stb_o = rx_sys_stb_q;
    assign rx_system_serial_data_o = rx_sys_data_q;
    assign rx_recovered_clock_o = rx_clk_q;
    assign receive_carrier_loss_o = los_q;
    assign los_change_latched_o = los_chg_q;
    assign jitter_limit_trip_flag_o = trip_q;
    assign ja_ref_tx_clock_o = ja_ref_q;
    assign ja_corner_mhz_o = corner_q;
    assign ja_level_o = level_q;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    property p_tx_off;
        !line_output_enable_pin_i [*5] |=> !tx_line_oe_o;
    endproperty
    a_tx_off: assert property (p_tx_off) else $error("Transmit not tristated.");

    property p_tx_on;
        line_output_enable_pin_i [*5] |=> tx_line_oe_o;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("Transmit not enabled.");

    property p_term_off;
        (rx_hitless_protect_bit_i && !line_output_enable_pin_i) [*5] |=> !rx_term_en_o;
    endproperty
    a_term_off: assert property (p_term_off) else $error("Termination kept.");

    property p_all_ones;
        (los_w && auto_all_ones_on_loss_i && mclk_bit_stb_i)
            |=> tx_line_stb_o && tx_line_data_o;
    endproperty
    a_all_ones: assert property (p_all_ones) else $error("No all-ones bit.");

    property p_rx_clk;
        los_w |=> rx_recovered_clock_o == $past(master_clock_t1_source_i);
    endproperty
    a_rx_clk: assert property (p_rx_clk) else $error("Wrong receive clock.");

    property p_local;
        (lb_local && tx_bit_stb_i) |=> rx_system_stb_o
            && rx_system_serial_data_o == $past(tx_system_serial_data_i);
    endproperty
    a_local: assert property (p_local) else $error("Local loop data lost.");

    property p_rem1;
        (lb_rem1 && !analog_lb_i && !auto_all_ones_on_loss_i && rx_bit_stb_i)
            |=> tx_line_stb_o && tx_line_data_o == $past(rx_line_data_i);
    endproperty
    a_rem1: assert property (p_rem1) else $error("Remote loop data lost.");

    property p_trip;
        (ja_active && ja_level > ja_lim) |=> jitter_limit_trip_flag_o
            ##1 (jitter_limit_trip_flag_o || $past(trip_clear_i));
    endproperty
    a_trip: assert property (p_trip) else $error("Trip flag not held.");

    property p_chg;
        (los_w != receive_carrier_loss_o) |=> los_change_latched_o;
    endproperty
    a_chg: assert property (p_chg) else $error("Loss change not latched.");

    c_loss: cover property ($rose(receive_carrier_loss_o));
    c_dual: cover property (dual_lb_i && tx_line_stb_o ##1 rx_system_stb_o);
    c_trip: cover property ($rose(jitter_limit_trip_flag_o));
    c_rem2: cover property (lb_rem2 && ja_out_stb);
endmodule : lulc_line_unit

// file: sim/lulc_line_model.sv
// Behavioural line partner: bit strobes, decoded data and level flags.
`timescale 1ns/1ns
module lulc_line_model (
    input wire logic sys_clk_i,
    input wire logic srst_i,
    input wire logic [1:0] mode_i,
    output logic bit_stb_o,
    output logic data_o,
    output logic level_ok_o,
    output logic level_low_o,
    output logic rec_clk_o
);
    // ****************************************************************
    // Line behaviour
    // ****************************************************************
    // Mode 0 is a dead line, 1 random traffic, 2 good level with no pulses.
    logic [1:0] div_q = 2'h0;
    logic [15:0] lfsr_q = 16'hace1;
    always @(posedge sys_clk_i) begin
        div_q <= srst_i ? 2'h0 : div_q + 2'h1;
        lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        bit_stb_o <= !srst_i && (div_q == 2'h3);
        // Between strobes the data line keeps changing, so nothing may rely on it.
        data_o <= (div_q == 2'h3 && mode_i != 2'h1) ? 1'b0 : lfsr_q[0];
        rec_clk_o <= srst_i ? 1'b0 : (rec_clk_o ^ (div_q == 2'h3));
    end
    assign level_ok_o = (mode_i != 2'h0);
    assign level_low_o = (mode_i == 2'h0);
endmodule : lulc_line_model

// file: sim/tb.sv
// Self-checking testbench for one port of the line unit control block.
`timescale 1ns/1ns
module tb;
    // ****************************************************************
    // Stimulus, model and design
    // ****************************************************************
    logic sys_clk_i = 1'b0, srst_i = 1'b1, pin = 1'b0, hitless = 1'b0, depth = 1'b0;
    logic path_hi = 1'b0, path_lo = 1'b0, t1 = 1'b0, ets = 1'b0, local_lb = 1'b0;
    logic remote1 = 1'b0, auto1 = 1'b0, mclk_src = 1'b0, mclk_stb = 1'b0, tx_stb = 1'b0;
    logic tx_data = 1'b0, los_clr = 1'b0, trip_clr = 1'b0, dual = 1'b0, d;
    logic [1:0] mode = 2'h0;
    logic rstb, rdata, rok, rlow, rclk;
    logic oe, lstb, ldata, term, sstb, sdata, rco, loss, latched, trip, ref_tx;
    logic [11:0] corner;
    logic [7:0] lvl;
    int mismatches = 0, n_compared = 0, seed = 32'h94e1f748, n;
    always #4 sys_clk_i = ~sys_clk_i;
    lulc_line_model u_line (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .mode_i(mode),
        .bit_stb_o(rstb), .data_o(rdata), .level_ok_o(rok), .level_low_o(rlow),
        .rec_clk_o(rclk));
    lulc_line_unit u_dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
        .line_output_enable_pin_i(pin), .rx_hitless_protect_bit_i(hitless),
        .jitter_buffer_depth_select_i(depth), .jitter_path_select_hi_i(path_hi),
        .jitter_path_select_lo_i(path_lo), .t1_mode_i(t1), .ets_mode_i(ets),
        .zero_sub_i(1'b0), .analog_lb_i(1'b0), .local_lb_i(local_lb), .remote_lb1_i(remote1),
        .remote_lb2_i(1'b0), .dual_lb_i(dual), .auto_all_ones_on_loss_i(auto1),
        .rx_bit_stb_i(rstb), .rx_line_data_i(rdata), .rx_level_ok_i(rok),
        .rx_level_low_i(rlow), .rx_recovered_clock_i(rclk), .master_clock_t1_source_i(mclk_src),
        .mclk_bit_stb_i(mclk_stb), .tx_bit_stb_i(tx_stb), .tx_system_serial_data_i(tx_data),
        .ja_smooth_stb_i(1'b0), .los_change_clear_i(los_clr), .trip_clear_i(trip_clr),
        .tx_line_oe_o(oe), .tx_line_stb_o(lstb), .tx_line_data_o(ldata), .rx_term_en_o(term),
        .rx_system_stb_o(sstb), .rx_system_serial_data_o(sdata), .rx_recovered_clock_o(rco),
        .receive_carrier_loss_o(loss), .los_change_latched_o(latched),
        .jitter_limit_trip_flag_o(trip), .ja_ref_tx_clock_o(ref_tx),
        .ja_corner_mhz_o(corner), .ja_level_o(lvl));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask : cyc
    // Waits for the loss flag, then checks that the bit count fell in range.
    task automatic wait_los(input logic v, input int lo_bits, input int hi_bits);
        n = 0;
        while (loss !== v && n < hi_bits * 4 + 8) begin
            cyc(1);
            n++;
        end
        check(loss, v);
        check(n >= lo_bits * 4 - 8, 1'b1);
    endtask : wait_los
    // Checks that the loss flag still holds its value just before it may change.
    task automatic hold_los(input logic v, input int bits);
        cyc(bits * 4 - 8);
        check(loss, v);
    endtask : hold_los
    task automatic pin_step(input logic p, input logic exp_term);
        @(posedge sys_clk_i);
        pin <= p;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while (oe !== p && n < 70);
        check(oe, p);
        check(term, exp_term);
        // One E1 bit period is 61 cycles at this clock.
        check(n <= 61, 1'b1);
    endtask : pin_step
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : give_verdict
    initial begin
        #600000;
        mismatches++;
        give_verdict;
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        cyc(20);
        @(posedge sys_clk_i);
        srst_i <= 1'b0;
        cyc(1);
        check({oe, term, loss, latched, trip}, 12'h0_00c);
        pin_step(1'b1, 1'b1);
        @(posedge sys_clk_i);
        hitless <= 1'b1;
        pin_step(1'b0, 1'b0);
        pin_step(1'b1, 1'b1);
        @(posedge sys_clk_i);
        hitless <= 1'b0;
        pin_step(1'b0, 1'b1);
        pin_step(1'b1, 1'b1);
        @(posedge sys_clk_i);
        mode <= 2'h1;
        wait_los(1'b0, 190, 200);
        check(latched, 1'b1);
        @(posedge sys_clk_i);
        los_clr <= 1'b1;
        @(posedge sys_clk_i);
        los_clr <= 1'b0;
        cyc(2);
        check(latched, 1'b0);
        @(posedge sys_clk_i);
        mode <= 2'h0;
        hold_los(1'b0, 185);
        wait_los(1'b1, 0, 12);
        check(corner, 12'h0_258);
        @(posedge sys_clk_i);
        auto1 <= 1'b1;
        mclk_src <= 1'b1;
        mclk_stb <= 1'b1;
        @(posedge sys_clk_i);
        mclk_stb <= 1'b0;
        #1;
        check({lstb, ldata, rco}, 12'h0_007);
        @(posedge sys_clk_i);
        mclk_src <= 1'b0;
        auto1 <= 1'b0;
        cyc(2);
        check(rco, 1'b0);
        @(posedge sys_clk_i);
        ets <= 1'b1;
        mode <= 2'h1;
        wait_los(1'b0, 190, 200);
        @(posedge sys_clk_i);
        mode <= 2'h0;
        hold_los(1'b0, 2030);
        wait_los(1'b1, 0, 24);
        @(posedge sys_clk_i);
        t1 <= 1'b1;
        ets <= 1'b0;
        mode <= 2'h2;
        cyc(1600);
        check(loss, 1'b1);
        check(corner, 12'h0_ea6);
        @(posedge sys_clk_i);
        mode <= 2'h1;
        wait_los(1'b0, 0, 400);
        @(posedge sys_clk_i);
        local_lb <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk_i);
            d = 1'($random(seed));
            tx_stb <= 1'b1;
            tx_data <= d;
            @(posedge sys_clk_i);
            tx_stb <= 1'b0;
            #1;
            check({sstb, sdata, lstb, ldata}, {8'h00, 1'b1, d, 1'b1, d});
        end
        @(posedge sys_clk_i);
        local_lb <= 1'b0;
        remote1 <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            do cyc(1); while (rstb !== 1'b1);
            d = rdata;
            cyc(1);
            check({lstb, ldata}, {1'b1, d});
        end
        @(posedge sys_clk_i);
        remote1 <= 1'b0;
        dual <= 1'b1;
        tx_stb <= 1'b1;
        tx_data <= 1'b1;
        @(posedge sys_clk_i);
        tx_stb <= 1'b0;
        #1;
        check({sstb, sdata}, 12'h0_003);
        @(posedge sys_clk_i);
        dual <= 1'b0;
        path_hi <= 1'b1;
        cyc(3);
        check(ref_tx, 1'b1);
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk_i);
            tx_stb <= 1'b1;
            tx_data <= 1'($random(seed));
            @(posedge sys_clk_i);
            tx_stb <= 1'b0;
        end
        cyc(3);
        check({trip, lvl}, 12'h0_120);
        @(posedge sys_clk_i);
        path_hi <= 1'b0;
        depth <= 1'b1;
        trip_clr <= 1'b1;
        @(posedge sys_clk_i);
        trip_clr <= 1'b0;
        cyc(3);
        check({trip, ref_tx}, 12'h0_000);
        give_verdict;
    end
endmodule : tb
